// *** common/sram_port_cfg.svh ***
// Purpose: timing constants and pin widths for the static memory port controller
// Assumes: 100 MHz clock, fastest speed grade figures
// Notes: times in ns; cycle counts derived from the clock period
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH
// ==========================================================
// Widths
`define ADDR_W 15
`define DATA_W 8
// ==========================================================
// Timing, printed figures and derived counts
`define CLK_PERIOD_NS 10
`define READ_PERIOD_MIN_NS 12
`define ADDRESS_ACCESS_TIME_NS 12
`define WRITE_PERIOD_MIN_NS 12
`define SELECT_TO_WRITE_END_NS 9
`define ADDR_SETUP_TO_WRITE_END_NS 9
`define WDATA_SETUP_NS 8
`define WE_FLOAT_NS 7
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC `CEIL_CYC(`READ_PERIOD_MIN_NS)
`define ACCESS_CYC (`CEIL_CYC(`ADDRESS_ACCESS_TIME_NS) + 1)
`define WRITE_CYC `CEIL_CYC(`WRITE_PERIOD_MIN_NS + `WE_FLOAT_NS)
`define WDATA_CYC `CEIL_CYC(`WDATA_SETUP_NS)
`define CNT_W 4
`define CNT_ONE 4'h1
`define CNT_ZERO 4'h0
`endif

// *** common/sram_port_pkg.sv ***
// Purpose: types for the static memory port controller
// Assumes: constants come from sram_port_cfg.svh
// Notes: one-hot state codes written out
package sram_port_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_END = 4'b1000
    } port_state_t;
endpackage

// *** verilog/cycle_timer.sv ***
// Purpose: down counter that measures pin phases in clock cycles
// Assumes: load and count in the same clock domain
// Notes: done is high while the count is zero
`timescale 1ns/100ps
`include "sram_port_cfg.svh"
module cycle_timer #(
    parameter int WIDTH = `CNT_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] value,
    output logic done
);
    logic [WIDTH-1:0] count;
    wire at_zero = (count == '0);
    initial begin
        if (WIDTH < 2) $error("cycle_timer width too small");
    end
    // ==========================================================
    // Counter; load wins over counting down
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (load) begin
            count <= value;
        end else if (!at_zero) begin
            count <= count - 1'b1;
        end
    end
    assign done = at_zero;
endmodule

// *** verilog/sram_port_ctrl.sv ***
// Purpose: controller that drives an asynchronous 32K x 8 static memory
// Assumes: the memory keeps its truth table; data_bus_in is synchronous
// Notes: one access at a time; req is taken in the idle state, even in the first cycle after reset while ready is still low
`timescale 1ns/100ps
`include "sram_port_cfg.svh"
module sram_port_ctrl
    import sram_port_pkg::*;
#(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic ready,
    output logic rdata_valid,
    output logic [DATA_W-1:0] rdata,
    output logic [ADDR_W-1:0] word_address,
    output logic select_n,
    output logic write_n,
    output logic drive_n,
    input wire logic [DATA_W-1:0] data_bus_in,
    output logic [DATA_W-1:0] data_bus_out,
    output logic data_bus_oe
);
    initial begin
        if (ADDR_W != `ADDR_W || DATA_W != `DATA_W) $error("port is 15 by 8 only");
    end

    port_state_t state;
    port_state_t next_state;
    logic timer_load;
    logic [`CNT_W-1:0] timer_value;
    logic timer_done;
    logic is_write;

    // ==========================================================
    // Phase timer
    cycle_timer #(.WIDTH(`CNT_W)) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .load(timer_load),
        .value(timer_value),
        .done(timer_done)
    );

    // Decode of the request and the phase transitions
    wire take = (state == ST_IDLE) && req;
    wire read_done = (state == ST_READ) && timer_done;
    wire write_done = (state == ST_WRITE) && timer_done;
    // Write phase covers write period plus strobe float, so it also meets data setup
    wire [`CNT_W-1:0] read_len = `CNT_W'(`ACCESS_CYC);
    wire [`CNT_W-1:0] write_len = `CNT_W'(`WRITE_CYC);
    assign timer_load = take || (state == ST_END);
    assign timer_value = take ? (req_write ? write_len : read_len) : `CNT_ZERO;

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req) next_state = req_write ? ST_WRITE : ST_READ;
            end
            ST_READ: begin
                if (timer_done) next_state = ST_END;
            end
            ST_WRITE: begin
                if (timer_done) next_state = ST_END;
            end
            ST_END: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // ==========================================================
    // State and request capture
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            is_write <= 1'b0;
        end else begin
            state <= next_state;
            if (take) is_write <= req_write;
        end
    end

    // Address lands with the select fall and stays to the end phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            word_address <= '0;
        end else if (take) begin
            word_address <= req_addr;
        end
    end

    // Pin controls; strobe and select rise together, memory floats then
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            select_n <= 1'b1;
            write_n <= 1'b1;
            drive_n <= 1'b1;
        end else begin
            select_n <= !(next_state == ST_READ || next_state == ST_WRITE);
            write_n <= !(next_state == ST_WRITE);
            drive_n <= !(next_state == ST_READ);
        end
    end

    // Our data drivers; data stays during the end phase for zero hold
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_bus_out <= '0;
            data_bus_oe <= 1'b0;
        end else begin
            if (take && req_write) data_bus_out <= req_wdata;
            data_bus_oe <= (next_state == ST_WRITE) ||
                           (state == ST_WRITE && next_state == ST_END);
        end
    end

    // Read capture at the final read cycle, past the access time
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= read_done;
            if (read_done) rdata <= data_bus_in;
        end
    end

    // Ready only in idle; the end phase spaces accesses apart
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b0;
        end else begin
            ready <= (next_state == ST_IDLE);
        end
    end

    // ==========================================================
    // Checks
    // Our data may stay one cycle past the joint rise for zero hold, never longer
    AST_SELECT_FLOATS: assert property (@(posedge clock) disable iff (!rst_n)
        select_n && !$rose(select_n) |-> !data_bus_oe)
        else $error("bus driven while deselected");
    AST_READ_NO_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
        !drive_n |-> write_n && !data_bus_oe) else $error("strobe in read");
    AST_WRITE_DRIVES: assert property (@(posedge clock) disable iff (!rst_n)
        !write_n |-> !select_n && data_bus_oe && drive_n) else $error("bad write");
    AST_WRITE_LEN: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(write_n) |-> !write_n [*2]) else $error("write too short");
    AST_DATA_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(write_n) |-> data_bus_oe && $stable(data_bus_out))
        else $error("write data not held");
    AST_ADDR_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        !select_n && !$fell(select_n) |-> $stable(word_address))
        else $error("address moved in access");
    AST_READ_LEN: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(drive_n) |-> !drive_n [*4] ##1 rdata_valid)
        else $error("read capture early");
    AST_JOINT_RISE: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(write_n) |-> select_n && drive_n) else $error("end not joint");
    AST_SPACING: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(select_n) |=> select_n) else $error("no gap");
endmodule

// *** dv/sram_device_model.sv ***
// Purpose: behavioural 32K x 8 static memory for the port tests
// Assumes: pins as driven by sram_port_ctrl
// Notes: a released bus shows the inverse of its last value
`timescale 1ns/100ps
module sram_device_model (
    input wire logic [14:0] word_address,
    input wire logic select_n,
    input wire logic write_n,
    input wire logic drive_n,
    input wire logic [7:0] data_bus_out,
    input wire logic data_bus_oe,
    output logic [7:0] data_bus_in
);
    // ==========
    // Storage and pin decode
    logic [7:0] mem [0:32767];
    logic [7:0] shown = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] wd;
    logic [14:0] wa;
    wire mem_on = !select_n && write_n && !drive_n;
    wire wr_on = !select_n && !write_n;
    // Old data lingers, then junk, so an early capture is caught
    always @(word_address or negedge select_n) begin
        #3 shown = ~shown;
        #9 shown = mem[word_address];
    end
    // Undriven bus must not look like valid data
    always @* begin
        if (data_bus_oe) data_bus_in = data_bus_out;
        else if (mem_on) data_bus_in = shown;
        else data_bus_in = ~last;
    end
    always @(data_bus_in) if (data_bus_oe || mem_on) last = data_bus_in;
    // Latch during the overlap, commit when its first signal rises
    always @* if (wr_on) begin
        wd = data_bus_in;
        wa = word_address;
    end
    always @(negedge wr_on) mem[wa] = wd;
endmodule

// *** dv/async_sram_32k_by_8_port_test.sv ***
// Purpose: self-checking bench for the static memory port controller
// Assumes: device model in sram_device_model.sv
// Notes: inputs change on the falling clock edge
`timescale 1ns/100ps
module async_sram_32k_by_8_port_test;
    // ==========
    // Clock, reset and wiring
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic req_write = 1'b0;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic ready, rdata_valid, select_n, write_n, drive_n, data_bus_oe;
    logic [7:0] rdata, data_bus_in, data_bus_out, got;
    logic [14:0] word_address;
    int n_errors = 0;
    int n_tests = 0;
    int sel_len = 0;
    int guard = 0;
    initial forever #5 clock = ~clock;
    sram_port_ctrl uut (.clock(clock), .rst_n(rst_n), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .ready(ready),
        .rdata_valid(rdata_valid), .rdata(rdata), .word_address(word_address),
        .select_n(select_n), .write_n(write_n), .drive_n(drive_n),
        .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
    sram_device_model far (.word_address(word_address), .select_n(select_n),
        .write_n(write_n), .drive_n(drive_n), .data_bus_out(data_bus_out),
        .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in));
    // ==========
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Pin watcher: select pulse length, strobe in reads, write contents
    always @(negedge clock) begin
        if (rst_n && !select_n) begin
            sel_len <= sel_len + 1;
            if (!drive_n) check(write_n, 1'b1);
            if (!write_n) check({data_bus_oe, word_address, data_bus_out},
                {1'b1, req_addr, req_wdata});
        end else if (rst_n && sel_len > 0) begin
            check(sel_len >= 2, 1'b1);
            sel_len <= 0;
        end
    end
    // ==========
    // Bus cycles; a hung handshake ends the run
    task automatic tick;
        @(negedge clock);
        guard++;
        if (guard > 40) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
        guard = 0;
        while (ready !== 1'b1) tick();
        req = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        tick();
        req = 1'b0;
        while (!wr && rdata_valid !== 1'b1) tick();
        got = rdata;
        while (ready !== 1'b1) tick();
    endtask
    // ==========
    // Scenarios
    task automatic scn_table;
        logic [14:0] ad [4] = '{15'h0000, 15'h7fff, 15'h5555, 15'h2aaa};
        logic [7:0] vl [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
        for (int i = 0; i < 4; i++) access(1'b1, ad[i], vl[i]);
        for (int i = 0; i < 4; i++) begin
            access(1'b0, ad[i], 8'h00);
            check(got, vl[i]);
        end
    endtask
    task automatic scn_overwrite;
        access(1'b1, 15'h1234, 8'h3c);
        access(1'b1, 15'h1234, 8'hc3);
        access(1'b0, 15'h1234, 8'h00);
        check(got, 8'hc3);
    endtask
    // Reset in mid-run releases the pins; memory keeps its contents
    task automatic scn_reset;
        rst_n = 1'b0;
        @(negedge clock);
        check({ready, select_n, write_n, drive_n, data_bus_oe}, 5'h0e);
        rst_n = 1'b1;
        access(1'b0, 15'h7fff, 8'h00);
        check(got, 8'h5a);
    endtask
    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        scn_table();
        scn_overwrite();
        scn_reset();
        tally_and_finish();
    end
endmodule
